/* File: core/fbc_regs.svh */
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH
// ----------------------------------------------------------------------
// Timing figures in ns and derived cycle counts at the reference clock
// ----------------------------------------------------------------------
`define FBC_CLK_NS        100
`define FBC_T_CE_NS       70
`define FBC_ADDRESS_ACCESS_TIME_NS      70
`define FBC_T_RP_NS       500
`define FBC_T_RH_NS       50
`define FBC_T_READY_NS    20000
`define FBC_T_WP_NS       35
// Read data passes two flops before the sequencer may take it.
`define FBC_SYNC_STAGES   2
`define FBC_CE_CYC   ((`FBC_T_CE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_RP_CYC   ((`FBC_T_RP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_RH_CYC   ((`FBC_T_RH_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_RDY_CYC  ((`FBC_T_READY_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_WP_CYC   ((`FBC_T_WP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
// ----------------------------------------------------------------------
// Sector decode fields (word address bits)
// ----------------------------------------------------------------------
`define FBC_SEC_TOP_MSB   19
`define FBC_SEC_TOP_LSB   15
`define FBC_SEC_BOOT_IDX  5'h1f
`define FBC_SEC_A14       14
`define FBC_SEC_A13       13
`define FBC_SEC_A12       12
`define FBC_SEC_31        6'h1f
`define FBC_SEC_32        6'h20
`define FBC_SEC_33        6'h21
`define FBC_SEC_34        6'h22
`define FBC_TOP_DATA_OR_LOW_ADDRESS_PIN          15
`endif

/* File: core/fbc_pkg.sv */
package fbc_pkg;
	typedef enum logic [1:0] {
		FBC_OP_READ,
		FBC_OP_WRITE,
		FBC_OP_RESET
	} fbc_op_e;

	typedef struct packed {
		fbc_op_e     op;
		logic        byte_mode;
		logic [19:0] addr;
		logic        addr_lsb;
		logic [15:0] wdata;
	} fbc_req_s;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        reset_n;
		logic        byte_n;
		logic [19:0] addr;
	} fbc_pins_s;
endpackage

/* File: core/fbc_host.sv */
`timescale 1ns/1ps
`include "fbc_regs.svh"

module fbc_host
	import fbc_pkg::*;
#(
	parameter int RDY_CYC = `FBC_RDY_CYC
)(
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_req_valid,
	output logic             o_req_ready,
	input  wire fbc_req_s    i_req,
	output logic             o_rsp_valid,
	output logic [15:0]      o_rsp_data,
	output logic [5:0]       o_sector_index,
	output logic             o_busy_seen,
	output fbc_pins_s        o_pins,
	input  wire logic [15:0] i_dq,
	output logic [15:0]      o_dq,
	output logic [15:0]      o_dq_oe,
	input  wire logic        i_ready_busy_n
);
	// ------------------------------------------------------------------
	// Types and helpers
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_RST, ST_RH, ST_RDYW} fbc_st_e;
	localparam logic [15:0] CE_N  = 16'(`FBC_CE_CYC);
	localparam logic [15:0] SYNC_N = 16'(`FBC_SYNC_STAGES);
	localparam logic [15:0] RP_N  = 16'(`FBC_RP_CYC);
	localparam logic [15:0] RH_N  = 16'(`FBC_RH_CYC);
	localparam logic [15:0] WP_N  = 16'(`FBC_WP_CYC);
	localparam logic [15:0] RDY_N = 16'(RDY_CYC);

	// Top-boot sector decode on the word address; the byte-mode lsb never matters.
	function automatic logic [5:0] sector_of(input logic [19:0] a);
		logic [4:0] top;
		top = a[`FBC_SEC_TOP_MSB:`FBC_SEC_TOP_LSB];
		if (top != `FBC_SEC_BOOT_IDX) sector_of = {1'b0, top};
		else if (!a[`FBC_SEC_A14]) sector_of = `FBC_SEC_31;
		else if (a[`FBC_SEC_A13]) sector_of = `FBC_SEC_34;
		else if (a[`FBC_SEC_A12]) sector_of = `FBC_SEC_33;
		else sector_of = `FBC_SEC_32;
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic [15:0] dq_m, dq_s;
	logic        rb_m, rb_s;
	always_ff @(posedge i_ref_clk) begin
		dq_m <= i_dq;
		dq_s <= dq_m;
		rb_m <= i_ready_busy_n;
		rb_s <= rb_m;
	end

	// ------------------------------------------------------------------
	// Bus sequencer
	// ------------------------------------------------------------------
	fbc_st_e     st, next_st;
	logic [15:0] cnt, next_cnt;
	fbc_req_s    cur, next_cur;
	fbc_pins_s   pins, next_pins;
	logic [15:0] rdata, next_rdata;
	logic        rvalid, next_rvalid;
	logic        drive, next_drive;
	logic        busy_seen, next_busy_seen;
	logic [5:0]  sec, next_sec;

	// One request at a time; after a read or write, pins reach standby only if no request arrives in the first idle cycle.
	always_comb begin
		next_st        = st;
		next_cnt       = cnt;
		next_cur       = cur;
		next_pins      = pins;
		next_rdata     = rdata;
		next_rvalid    = 1'b0;
		next_drive     = drive;
		next_busy_seen = busy_seen;
		next_sec       = sec;
		case (st)
			ST_IDLE: begin
				// Idle: chip select and reset high put the device in standby.
				next_pins.ce_n    = 1'b1;
				next_pins.oe_n    = 1'b1;
				next_pins.we_n    = 1'b1;
				next_pins.reset_n = 1'b1;
				next_drive        = 1'b0;
				if (i_req_valid) begin
					next_cur          = i_req;
					next_sec          = sector_of(i_req.addr);
					next_pins.byte_n  = ~i_req.byte_mode;
					next_pins.addr    = i_req.addr;
					next_cnt          = 16'h0000;
					case (i_req.op)
						FBC_OP_READ: begin
							next_pins.ce_n = 1'b0;
							next_pins.oe_n = 1'b0;
							next_st        = ST_RD;
						end
						FBC_OP_WRITE: begin
							next_pins.ce_n = 1'b0;
							next_pins.we_n = 1'b0;
							next_drive     = 1'b1;
							next_st        = ST_WR;
						end
						default: begin
							next_pins.reset_n = 1'b0;
							next_st           = ST_RST;
						end
					endcase
				end
			end
			ST_RD: begin
				// Wait chip-select access plus the two synchroniser stages.
				next_cnt = cnt + 16'h0001;
				if (cnt >= CE_N + SYNC_N) begin
					next_rdata = cur.byte_mode ? {8'h00, dq_s[7:0]} : dq_s;
					next_rvalid = 1'b1;
					next_st = ST_IDLE;
				end
			end
			ST_WR: begin
				next_cnt = cnt + 16'h0001;
				if (cnt + 16'h0001 >= WP_N) begin
					next_pins.we_n = 1'b1;
					next_st = ST_IDLE;
				end
			end
			ST_RST: begin
				// Sample busy on every cycle of the pulse so software knows an operation was aborted.
				next_cnt = cnt + 16'h0001;
				if (!rb_s) next_busy_seen = 1'b1;
				if (cnt + 16'h0001 >= RP_N) begin
					next_pins.reset_n = 1'b1;
					next_cnt = 16'h0000;
					next_st = ST_RH;
				end
			end
			ST_RH: begin
				next_cnt = cnt + 16'h0001;
				if (cnt + 16'h0001 >= RH_N) begin
					next_cnt = 16'h0000;
					next_st = ST_RDYW;
				end
			end
			default: begin
				// Busy stays low until the internal reset ends; bounded by the ready time.
				next_cnt = cnt + 16'h0001;
				if (rb_s || cnt >= RDY_N) begin
					next_rvalid = 1'b1;
					next_st = ST_IDLE;
				end
			end
		endcase
		if (st == ST_IDLE && i_req_valid && i_req.op != FBC_OP_RESET) next_busy_seen = 1'b0;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			st        <= ST_IDLE;
			cnt       <= 16'h0000;
			cur       <= '0;
			pins      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1,
			               byte_n: 1'b1, addr: 20'h00000};
			rdata     <= 16'h0000;
			rvalid    <= 1'b0;
			drive     <= 1'b0;
			busy_seen <= 1'b0;
			sec       <= 6'h00;
		end else begin
			st        <= next_st;
			cnt       <= next_cnt;
			cur       <= next_cur;
			pins      <= next_pins;
			rdata     <= next_rdata;
			rvalid    <= next_rvalid;
			drive     <= next_drive;
			busy_seen <= next_busy_seen;
			sec       <= next_sec;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_req_ready    = (st == ST_IDLE);
	assign o_rsp_valid    = rvalid;
	assign o_rsp_data     = rdata;
	assign o_sector_index = sec;
	assign o_busy_seen    = busy_seen;
	assign o_pins         = pins;
	// Byte mode: the top pin carries the low address, bits 8..14 stay undriven.
	always_comb begin
		o_dq    = cur.wdata;
		o_dq_oe = drive ? (cur.byte_mode ? 16'h00ff : 16'hffff) : 16'h0000;
		if (cur.byte_mode && st != ST_IDLE) begin
			o_dq[`FBC_TOP_DATA_OR_LOW_ADDRESS_PIN]    = cur.addr_lsb;
			o_dq_oe[`FBC_TOP_DATA_OR_LOW_ADDRESS_PIN] = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_read_pins;
		@(posedge i_ref_clk) disable iff (i_srst)
		(st == ST_RD) |-> (!pins.ce_n && !pins.oe_n && pins.we_n);
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("read pins wrong");

	property p_read_wait;
		@(posedge i_ref_clk) disable iff (i_srst)
		$rose(st == ST_RD) |-> !rvalid [*3];
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read too early");

	property p_rst_width;
		@(posedge i_ref_clk) disable iff (i_srst)
		$fell(pins.reset_n) |-> !pins.reset_n [*5];
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("reset pulse short");

	property p_recovery;
		@(posedge i_ref_clk) disable iff (i_srst)
		$rose(pins.reset_n) |-> pins.oe_n [*2];
	endproperty
	a_recovery: assert property (p_recovery) else $error("read inside recovery");

	property p_no_contend;
		@(posedge i_ref_clk) disable iff (i_srst)
		!pins.oe_n |-> (o_dq_oe[7:0] == 8'h00);
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("bus contention");

	property p_idle_standby;
		@(posedge i_ref_clk) disable iff (i_srst)
		(st == ST_IDLE && $past(st) == ST_IDLE) |-> (pins.ce_n && pins.reset_n);
	endproperty
	a_idle_standby: assert property (p_idle_standby) else $error("idle not standby");

	property p_sector;
		@(posedge i_ref_clk) disable iff (i_srst)
		(o_req_ready && i_req_valid) |=> (sec <= `FBC_SEC_34);
	endproperty
	a_sector: assert property (p_sector) else $error("sector out of range");

	property p_byte_float;
		@(posedge i_ref_clk) disable iff (i_srst)
		cur.byte_mode |-> (o_dq_oe[14:8] == 7'h00);
	endproperty
	a_byte_float: assert property (p_byte_float) else $error("byte mode drives high");

	c_read:  cover property (@(posedge i_ref_clk) st == ST_RD ##[1:8] rvalid);
	c_write: cover property (@(posedge i_ref_clk) st == ST_WR);
	c_reset: cover property (@(posedge i_ref_clk) st == ST_RST ##[1:400] st == ST_IDLE);
endmodule // fbc_host

/* File: test/fbc_flash_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module fbc_flash_model
	import fbc_pkg::*;
#(
	parameter int         RST_CYC = 6,
	parameter int         OP_CYC  = 40,
	parameter int         SLP_CYC = 1,
	parameter logic [7:0] STATUS  = 8'h5a
)(
	input  wire logic        i_ref_clk,
	input  wire fbc_pins_s   i_pins,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_start,
	output logic [15:0]      o_dq,
	output logic             o_oe,
	output logic             o_ready_busy_n
);
	logic [15:0] mem [16];
	int          op_cnt;
	int          rst_cnt;
	logic [3:0]  a;
	logic [19:0] last_addr;
	int          stable_cnt;
	logic        asleep;
	logic [15:0] view;
	logic [15:0] held;

	// Outputs float unless a plain read selects us.
	assign a = i_pins.addr[3:0];
	assign o_oe = !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n && i_pins.reset_n;
	assign o_ready_busy_n = (op_cnt == 0) && (rst_cnt == 0);
	// Status replaces array data while an operation runs.
	always_comb begin
		if (op_cnt != 0) view = {8'h00, STATUS};
		else if (!i_pins.byte_n) view = {8'h00, i_dq[15] ? mem[a][15:8] : mem[a][7:0]};
		else view = mem[a];
	end
	// Sleep follows address stability alone; a new address leaves it at once.
	assign asleep = (stable_cnt >= SLP_CYC) && (i_pins.addr === last_addr);
	assign o_dq = asleep ? held : view;
	// The held word is refreshed every clock, so a sleeping read lags view by at most one clock.
	always @(posedge i_ref_clk) begin
		if (i_pins.addr !== last_addr) stable_cnt <= 0;
		else if (stable_cnt < SLP_CYC) stable_cnt <= stable_cnt + 1;
		last_addr <= i_pins.addr;
		held <= view;
	end
	initial foreach (mem[i]) mem[i] = 16'h0;
	// Reset aborts a running operation and only then holds busy low for a while; the operation ignores chip select.
	always @(posedge i_ref_clk) begin
		if (!i_pins.reset_n) begin
			if (op_cnt != 0 || rst_cnt != 0) rst_cnt <= RST_CYC;
			op_cnt <= 0;
		end else begin
			if (rst_cnt != 0) rst_cnt <= rst_cnt - 1;
			if (op_cnt != 0) op_cnt <= op_cnt - 1;
			else if (i_start) op_cnt <= OP_CYC;
			else if (!i_pins.ce_n && !i_pins.we_n && i_pins.oe_n) begin
				// Byte mode programs one lane, chosen by the low address on the top pin.
				if (i_pins.byte_n) mem[a] <= i_dq;
				else if (i_dq[15]) mem[a][15:8] <= i_dq[7:0];
				else mem[a][7:0] <= i_dq[7:0];
			end
		end
	end
endmodule // fbc_flash_model

/* File: test/flash_bus_power_reset_modes_tb.sv */
`timescale 1ns/1ps
module flash_bus_power_reset_modes_tb;
	import fbc_pkg::*;
	logic        i_ref_clk, i_srst, req_valid, req_ready, rsp_valid, busy_seen, f_oe, rbn, start;
	fbc_req_s    req;
	fbc_pins_s   pins;
	logic [15:0] rsp_data, h_dq, h_oe, f_dq, bus, pat;
	logic [5:0]  sec;
	logic [15:0] exp_mem [16];
	int          err_count, num_checks;

	fbc_host #(.RDY_CYC(8)) i_fbc_host(.i_ref_clk(i_ref_clk), .i_srst(i_srst),
		.i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req),
		.o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_sector_index(sec),
		.o_busy_seen(busy_seen), .o_pins(pins), .i_dq(bus), .o_dq(h_dq),
		.o_dq_oe(h_oe), .i_ready_busy_n(rbn));
	fbc_flash_model i_fbc_flash_model(.i_ref_clk(i_ref_clk), .i_pins(pins), .i_dq(bus),
		.i_start(start), .o_dq(f_dq), .o_oe(f_oe), .o_ready_busy_n(rbn));

	// Released lines toggle so that stale data never passes for a read.
	assign bus = (f_dq & {16{f_oe}}) | (h_dq & h_oe) | (pat & ~h_oe & ~{16{f_oe}});
	always @(posedge i_ref_clk) pat <= ~pat;
	// Clock generation.
	initial begin
		i_ref_clk = 0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	function automatic logic [15:0] sec_of(logic [19:0] a);
		if (a[19:15] != 5'h1f) return {11'h0, a[19:15]};
		if (!a[14]) return 16'h1f;
		if (a[13]) return 16'h22;
		return a[12] ? 16'h21 : 16'h20;
	endfunction

	// One request; waits for the answer unless it is a write. A high wm selects word mode.
	task automatic xfer(fbc_op_e op, logic wm, logic [19:0] a, logic [15:0] wd);
		int n;
		@(negedge i_ref_clk);
		req = '{op, ~wm, a, a[0], wd};
		req_valid = 1;
		n = 0;
		while (!req_ready && n < 50) begin
			@(negedge i_ref_clk);
			n++;
		end
		@(negedge i_ref_clk);
		req_valid = 0;
		n = 0;
		while (op != FBC_OP_WRITE && n < 40) begin
			@(posedge i_ref_clk);
			#1;
			if (rsp_valid === 1'b1) break;
			n++;
		end
		if (n == 40) chk("rsp_valid", 16'h0, 16'h1);
	endtask

	// Watchdog sized well above the expected run.
	initial begin
		#(100 * 20000);
		err_count++;
		final_report();
	end

	// Main sequence.
	initial begin
		logic [19:0] a;
		logic [15:0] d;
		logic [19:0] cor [8];
		cor = '{20'hf8000, 20'hfbfff, 20'hfc000, 20'hfd000, 20'hfe000, 20'hfffff, 20'h0, 20'hf7fff};
		i_srst = 1;
		req_valid = 0;
		req = '0;
		start = 0;
		pat = 16'ha5c3;
		err_count = 0;
		num_checks = 0;
		foreach (exp_mem[i]) exp_mem[i] = 16'h0;
		void'($urandom(32'h3e7c));
		repeat (8) @(negedge i_ref_clk);
		i_srst = 0;
		xfer(FBC_OP_RESET, 1, 0, 0);
		chk("busy_seen", {15'h0, busy_seen}, 16'h0);
		$display("test idle reset done");
		for (int i = 0; i < 8; i++) begin
			a = $urandom;
			d = $urandom;
			xfer(FBC_OP_WRITE, 1, a, d);
			exp_mem[a[3:0]] = d;
			xfer(FBC_OP_READ, 1, a, 0);
			chk("read", rsp_data, d);
			chk("sector", {10'h0, sec}, sec_of(a));
		end
		$display("test write read done");
		foreach (cor[i]) begin
			xfer(FBC_OP_READ, 1, cor[i], 0);
			chk("sector", {10'h0, sec}, sec_of(cor[i]));
		end
		a = $urandom;
		d = exp_mem[a[3:0]];
		xfer(FBC_OP_READ, 0, a, 0);
		chk("byte read", rsp_data, {8'h00, a[0] ? d[15:8] : d[7:0]});
		a = $urandom;
		d = $urandom;
		xfer(FBC_OP_WRITE, 0, a, d);
		if (a[0]) exp_mem[a[3:0]][15:8] = d[7:0];
		else exp_mem[a[3:0]][7:0] = d[7:0];
		xfer(FBC_OP_READ, 0, a, 0);
		chk("byte write read", rsp_data, {8'h00, d[7:0]});
		xfer(FBC_OP_READ, 1, a, 0);
		chk("word after byte", rsp_data, exp_mem[a[3:0]]);
		d = exp_mem[a[3:0]];
		$display("test sectors and byte mode done");
		@(negedge i_ref_clk) start = 1;
		@(negedge i_ref_clk) start = 0;
		xfer(FBC_OP_READ, 1, a, 0);
		chk("status", rsp_data, 16'h005a);
		xfer(FBC_OP_RESET, 1, 0, 0);
		chk("busy_seen", {15'h0, busy_seen}, 16'h1);
		xfer(FBC_OP_READ, 1, a, 0);
		chk("read after reset", rsp_data, d);
		$display("test busy reset done");
		final_report();
	end
endmodule // flash_bus_power_reset_modes_tb
